// file: bench/omd_cpu_model.sv
// Purpose: core-side requester model
// Assumes: called on a falling clock edge
// Notes: holds each request until the next call
`timescale 1ns/100ps
module omd_cpu_model (
  output logic req_o,
  output logic [23:0] addr_o,
  output logic write_o,
  output logic fetch_o
);
  initial {req_o, addr_o, write_o, fetch_o} = 27'h0;
  task automatic access(input logic [23:0] a, input logic w, f, b);
    req_o = 1'b1;
    write_o = w;
    fetch_o = f;
    // Word accesses only, except bootstrap writes below 0x010000, which are lifted into segment one with bit 0 kept
    addr_o = (b && w && a < 24'h010000) ? a + 24'h010000 : {a[23:1], 1'b0};
  endtask
endmodule // omd_cpu_model

// file: bench/omd_decoder_props.sv
// Purpose: port checks for the memory map decoder
// Assumes: selects follow a sampled request by one cycle
// Notes: watches only the ports it needs
`timescale 1ns/100ps
module omd_decoder_props (
  input wire clock_i,
  input wire reset_i,
  input wire req_i,
  input wire [23:0] addr_i,
  input wire [15:0] system_config_reg_i,
  input wire [15:0] xbus_peripheral_enable_reg_i,
  input wire small_ext_ram_sel_o,
  input wire large_ext_ram_sel_o,
  input wire first_can_sel_o,
  input wire second_can_sel_o,
  input wire external_sel_o,
  input wire [1:0] wait_states_o,
  input wire [3:0] seg_lines_o
);
  // ==========
  // Checks
  wire g = system_config_reg_i[2];
  wire [15:0] e = xbus_peripheral_enable_reg_i;
  wire [15:0] p = addr_i[23:8];
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence c1; req_i && p == 16'h00ef; endsequence
  sequence c2; req_i && p == 16'h00ee; endsequence
  sequence r1; req_i && p[15:3] == 13'h001c; endsequence
  sequence r2; req_i && addr_i[23:16] == 8'h09; endsequence
  sequence c1_gone; !first_can_sel_o && external_sel_o; endsequence
  first_can_sel_a: assert property (c1 ##0 (g && e[0]) |=> first_can_sel_o)
    else $error("first can select missing");
  first_can_off_a: assert property (c1 ##0 !(g && e[0]) |=> c1_gone)
    else $error("disabled can still visible");
  wait_two_a: assert property ($rose(first_can_sel_o) |-> wait_states_o == 2'h2)
    else $error("wait count wrong");
  second_can_sel_a: assert property (c2 ##0 (g && e[1]) |=> second_can_sel_o)
    else $error("second can select missing");
  sram_on_a: assert property (r1 ##0 (g && e[2]) |=> small_ext_ram_sel_o)
    else $error("small ram select missing");
  sram_fwd_a: assert property (r1 ##0 !(g && e[2]) |=> external_sel_o)
    else $error("small ram access not forwarded");
  lram_hit_a: assert property (r2 ##0 (g && e[3]) |=> large_ext_ram_sel_o)
    else $error("large ram select missing");
  seg_four_a: assert property (g && (e[0] || e[1]) |=> seg_lines_o == 4'h4)
    else $error("segment line count wrong");
  seg_eight_a: assert property (!(g && (e[0] || e[1])) |=> seg_lines_o == 4'h8)
    else $error("full segment lines missing");
endmodule // omd_decoder_props
bind omd_decoder omd_decoder_props i_omd_decoder_props (
  .clock_i(clock_i),
  .reset_i(reset_i),
  .req_i(req_i),
  .addr_i(addr_i),
  .system_config_reg_i(system_config_reg_i),
  .xbus_peripheral_enable_reg_i(xbus_peripheral_enable_reg_i),
  .small_ext_ram_sel_o(small_ext_ram_sel_o),
  .large_ext_ram_sel_o(large_ext_ram_sel_o),
  .first_can_sel_o(first_can_sel_o),
  .second_can_sel_o(second_can_sel_o),
  .external_sel_o(external_sel_o),
  .wait_states_o(wait_states_o),
  .seg_lines_o(seg_lines_o)
);

// file: bench/omd_decoder_tb.sv
// Purpose: directed test of the memory map decoder
// Assumes: inputs change on the falling edge
// Notes: each access is checked on the falling edge after it is sampled
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module omd_decoder_tb;
  logic clock_i = 0, reset_i = 1, prg = 0, bt = 0, rmp = 0;
  logic [15:0] sc = 0, xe = 0;
  logic [15:0] exp_sel;
  wire rq, wr, ft, wf, dm, wo;
  wire [23:0] ad;
  wire [15:0] sel;
  wire [1:0] ws;
  wire [2:0] sec;
  wire [3:0] seg;
  wire [13:0] lra;
  int errors = 0, n_tests = 0;
  int bits[8] = '{0, 1, 4, 6, 7, 8, 9, 10};
  logic [7:0] pg[8] = '{8'hef, 8'hee, 8'hed, 8'hec, 8'he9, 8'he8, 8'hea, 8'heb};
  initial forever #5 clock_i = ~clock_i;
  omd_cpu_model i_omd_cpu_model (.req_o(rq), .addr_o(ad), .write_o(wr), .fetch_o(ft));
  omd_decoder i_omd_decoder (.clock_i(clock_i), .reset_i(reset_i), .req_i(rq), .addr_i(ad),
    .write_i(wr), .fetch_i(ft), .prog_op_i(prg), .bootstrap_i(bt), .segment_one_remap_i(rmp),
    .system_config_reg_i(sc), .xbus_peripheral_enable_reg_i(xe), .small_ext_ram_sel_o(sel[15]),
    .large_ext_ram_sel_o(sel[14]), .large_ext_ram_addr_o(lra), .first_can_sel_o(sel[13]),
    .second_can_sel_o(sel[12]), .rtc_sel_o(sel[11]), .pwm_sel_o(sel[10]), .asc_sel_o(sel[9]),
    .ssc_sel_o(sel[8]), .i2c_sel_o(sel[7]), .misc_sel_o(sel[6]), .sfr_sel_o(sel[5]),
    .flash_sector_sel_o(sel[4]), .flash_sector_o(sec), .test_sector_sel_o(sel[3]),
    .flash_ctrl_sel_o(sel[2]), .flash_reserved_sel_o(sel[1]), .external_sel_o(sel[0]),
    .wait_states_o(ws), .demux_addr_o(dm), .word_only_o(wo), .wide_fetch_o(wf),
    .seg_lines_o(seg));
  // ==========
  // Access tasks
  task automatic go(input logic [23:0] a, input logic w, f, input logic [15:0] es);
    i_omd_cpu_model.access(a, w, f, bt);
    @(negedge clock_i);
    `CHK("select", es, sel)
  endtask
  task automatic fl(input logic [23:0] a, input logic w, f, input logic [2:0] s);
    go(a, w, f, 16'h0010);
    `CHK("sector", s, sec)
  endtask
  task finish_test;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial #200000 begin
    errors++;
    finish_test;
  end
  // ==========
  // Sequence
  initial begin
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    reset_i = 0;
    @(negedge clock_i);
    `CHK("lines", 4'h8, seg)
    sc = 16'h0004;
    for (int i = 0; i < 8; i++) begin
      xe = 16'h1 << bits[i];
      exp_sel = 16'h2000 >> i;
      go({8'h00, pg[i], 8'h10}, 0, 0, exp_sel);
      `CHK("profile", 4'hb, {ws, dm, wo})
      `CHK("lines", (i < 2) ? 4'h4 : 4'h8, seg)
      xe = ~(16'h1 << bits[i]);
      go({8'h00, pg[i], 8'hfe}, 1, 0, 16'h0001);
      `CHK("lines", 4'h4, seg)
    end
    // Mid-run reset with a request and both CAN enables still up
    reset_i = 1;
    @(negedge clock_i);
    `CHK("reset", 20'h00008, {sel, seg})
    reset_i = 0;
    xe = 16'h0004;
    go(24'h00e7fe, 0, 0, 16'h8000);
    `CHK("profile", 4'h2, {ws, dm, wo})
    sc = 16'h0000;
    go(24'h00e000, 1, 0, 16'h0001);
    sc = 16'h0004;
    xe = 16'h0008;
    go(24'h09c004, 1, 0, 16'h4000);
    `CHK("mirror", 14'h0004, lra)
    go(24'h00f3fe, 0, 0, 16'h0020);
    `CHK("profile", 4'h1, {ws, dm, wo})
    go(24'h050000, 0, 0, 16'h0002);
    go(24'h08fffe, 0, 0, 16'h0004);
    fl(24'h007ffe, 0, 0, 3'h3);
    fl(24'h018000, 0, 1, 3'h4);
    `CHK("fetch", 1'b1, wf)
    fl(24'h02fffe, 0, 0, 3'h5);
    `CHK("fetch", 1'b0, wf)
    prg = 1;
    fl(24'h012000, 1, 0, 3'h1);
    prg = 0;
    rmp = 1;
    fl(24'h016000, 0, 0, 3'h3);
    rmp = 0;
    bt = 1;
    go(24'h000100, 0, 1, 16'h0008);
    `CHK("fetch", 1'b1, wf)
    go(24'h020000, 0, 1, 16'h0001);
    `CHK("fetch", 1'b0, wf)
    fl(24'h000100, 0, 0, 3'h0);
    fl(24'h002000, 1, 0, 3'h1);
    rmp = 1;
    go(24'h000100, 0, 0, 16'h0008);
    fl(24'h010100, 0, 0, 3'h0);
    finish_test;
  end
endmodule // omd_decoder_tb

// file: verilog/omd_decoder.v
// Purpose: address decoder for the unified 16 MB space
// Assumes: one access request per cycle, addresses synchronous to clock_i
// Notes: selects and profile are registered, valid one cycle after the request
`timescale 1ns/100ps
`include "omd_regs.vh"
module omd_decoder #(
  parameter LRAM_BASE = `OMD_LRAM_BASE
) (
  input wire clock_i,
  input wire reset_i,
  input wire req_i,
  input wire [23:0] addr_i,
  input wire write_i,
  input wire fetch_i,
  input wire prog_op_i,
  input wire bootstrap_i,
  input wire segment_one_remap_i,
  input wire [15:0] system_config_reg_i,
  input wire [15:0] xbus_peripheral_enable_reg_i,
  output reg small_ext_ram_sel_o,
  output reg large_ext_ram_sel_o,
  output reg [13:0] large_ext_ram_addr_o,
  output reg first_can_sel_o,
  output reg second_can_sel_o,
  output reg rtc_sel_o,
  output reg pwm_sel_o,
  output reg asc_sel_o,
  output reg ssc_sel_o,
  output reg i2c_sel_o,
  output reg misc_sel_o,
  output reg sfr_sel_o,
  output reg flash_sector_sel_o,
  output reg [2:0] flash_sector_o,
  output reg test_sector_sel_o,
  output reg flash_ctrl_sel_o,
  output reg flash_reserved_sel_o,
  output reg external_sel_o,
  output reg [1:0] wait_states_o,
  output reg demux_addr_o,
  output reg word_only_o,
  output reg wide_fetch_o,
  output reg [3:0] seg_lines_o
);

  // ==================================================
  // Enables
  wire xbus_global_enable = system_config_reg_i[`OMD_GLOBAL_EN_BIT];
  wire [15:0] pe = xbus_peripheral_enable_reg_i & {16{xbus_global_enable}};
  wire small_ext_ram_enable = pe[`OMD_EN_SRAM];
  wire large_ext_ram_enable = pe[`OMD_EN_LRAM];
  wire first_can_enable = pe[`OMD_EN_FIRST_CAN];
  wire second_can_enable = pe[`OMD_EN_SECOND_CAN];

  // ==================================================
  // Address windows
  // Upper bits inside the large RAM region are ignored, so the image repeats
  localparam [23:0] LRAM_LAST = LRAM_BASE + `OMD_LRAM_SPAN;
  wire win_sram;
  wire win_lram;
  wire win_first_can;
  wire win_second_can;
  wire win_rtc;
  wire win_pwm;
  wire win_asc;
  wire win_ssc;
  wire win_i2c;
  wire win_misc;
  wire win_sfr;
  wire win_fctl;
  wire win_frsv;

  omd_window_hit #(
    .LO(`OMD_SRAM_LO),
    .HI(`OMD_SRAM_HI)
  ) i_sram_win (
    .addr_i(addr_i),
    .hit_o(win_sram)
  );

  omd_window_hit #(
    .LO(LRAM_BASE),
    .HI(LRAM_LAST)
  ) i_lram_win (
    .addr_i(addr_i),
    .hit_o(win_lram)
  );

  omd_window_hit #(
    .LO({`OMD_PAGE_FIRST_CAN, 8'h00}),
    .HI({`OMD_PAGE_FIRST_CAN, 8'hff})
  ) i_first_can_win (
    .addr_i(addr_i),
    .hit_o(win_first_can)
  );

  omd_window_hit #(
    .LO({`OMD_PAGE_SECOND_CAN, 8'h00}),
    .HI({`OMD_PAGE_SECOND_CAN, 8'hff})
  ) i_second_can_win (
    .addr_i(addr_i),
    .hit_o(win_second_can)
  );

  omd_window_hit #(
    .LO({`OMD_PAGE_RTC, 8'h00}),
    .HI({`OMD_PAGE_RTC, 8'hff})
  ) i_rtc_win (
    .addr_i(addr_i),
    .hit_o(win_rtc)
  );

  omd_window_hit #(
    .LO({`OMD_PAGE_PWM, 8'h00}),
    .HI({`OMD_PAGE_PWM, 8'hff})
  ) i_pwm_win (
    .addr_i(addr_i),
    .hit_o(win_pwm)
  );

  omd_window_hit #(
    .LO({`OMD_PAGE_ASC, 8'h00}),
    .HI({`OMD_PAGE_ASC, 8'hff})
  ) i_asc_win (
    .addr_i(addr_i),
    .hit_o(win_asc)
  );

  omd_window_hit #(
    .LO({`OMD_PAGE_SSC, 8'h00}),
    .HI({`OMD_PAGE_SSC, 8'hff})
  ) i_ssc_win (
    .addr_i(addr_i),
    .hit_o(win_ssc)
  );

  omd_window_hit #(
    .LO({`OMD_PAGE_I2C, 8'h00}),
    .HI({`OMD_PAGE_I2C, 8'hff})
  ) i_i2c_win (
    .addr_i(addr_i),
    .hit_o(win_i2c)
  );

  omd_window_hit #(
    .LO({`OMD_PAGE_MISC, 8'h00}),
    .HI({`OMD_PAGE_MISC, 8'hff})
  ) i_misc_win (
    .addr_i(addr_i),
    .hit_o(win_misc)
  );

  omd_window_hit #(
    .LO(`OMD_SFR_LO),
    .HI(`OMD_SFR_HI)
  ) i_sfr_win (
    .addr_i(addr_i),
    .hit_o(win_sfr)
  );

  omd_window_hit #(
    .LO(`OMD_FCTL_LO),
    .HI(`OMD_FCTL_HI)
  ) i_fctl_win (
    .addr_i(addr_i),
    .hit_o(win_fctl)
  );

  omd_window_hit #(
    .LO(`OMD_FRSV_LO),
    .HI(`OMD_FRSV_HI)
  ) i_frsv_win (
    .addr_i(addr_i),
    .hit_o(win_frsv)
  );

  // ==================================================
  // Window hits
  // A disabled unit claims nothing, so its window falls through to external
  wire hit_sram = small_ext_ram_enable && win_sram;
  wire hit_lram = large_ext_ram_enable && win_lram;
  wire hit_first_can = first_can_enable && win_first_can;
  wire hit_second_can = second_can_enable && win_second_can;
  wire hit_rtc = pe[`OMD_EN_RTC] && win_rtc;
  wire hit_pwm = pe[`OMD_EN_PWM] && win_pwm;
  wire hit_asc = pe[`OMD_EN_ASC] && win_asc;
  wire hit_ssc = pe[`OMD_EN_SSC] && win_ssc;
  wire hit_i2c = pe[`OMD_EN_I2C] && win_i2c;
  wire hit_misc = pe[`OMD_EN_MISC] && win_misc;
  wire hit_per = hit_first_can | hit_second_can | hit_rtc | hit_pwm | hit_asc | hit_ssc
    | hit_i2c | hit_misc;
  wire hit_sfr = win_sfr;

  // ==================================================
  // Flash mapping
  // Segment-one map applies to program/erase, remap bit, and all bootstrap
  // writes; bootstrap reads follow the remap bit and program/erase only.
  wire seg1_map = prog_op_i || segment_one_remap_i
    || (bootstrap_i && write_i);
  reg f_sect_hit;
  reg f_test_hit;
  reg [2:0] f_sect;
  always @* begin
    f_sect_hit = 1'b0;
    f_test_hit = 1'b0;
    f_sect = 3'h0;
    if (addr_i <= `OMD_FLASH_HI) begin
      if (addr_i >= `OMD_SECT4_LO) begin
        f_sect_hit = 1'b1;
        f_sect = (addr_i[23:16] == 8'h01) ? 3'h4 : addr_i[18:16] + 3'h3;
      end else if (seg1_map) begin
        if (addr_i >= `OMD_SEG1_LO && addr_i <= `OMD_SEG1_SECT_HI) begin
          f_sect_hit = 1'b1;
          f_sect = {1'b0, addr_i[14:13]};
        end else if (addr_i <= `OMD_TEST_HI) begin
          f_test_hit = 1'b1;
        end
      end else if (addr_i <= `OMD_LOW_SECT_HI) begin
        f_sect_hit = 1'b1;
        f_sect = {1'b0, addr_i[14:13]};
      end
    end
    // Bootstrap: test sector fetched at zero, user flash never fetched
    if (bootstrap_i && fetch_i) begin
      f_sect_hit = 1'b0;
      f_test_hit = addr_i <= `OMD_TEST_HI;
    end
    // Test sector is invisible outside bootstrap mode
    if (!bootstrap_i) begin
      f_test_hit = 1'b0;
    end
  end
  wire hit_fctl = win_fctl;
  wire hit_frsv = win_frsv;
  wire hit_any = hit_sram | hit_lram | hit_per | hit_sfr | f_sect_hit | f_test_hit
    | hit_fctl | hit_frsv;

  // ==================================================
  // Registered outputs
  always @(posedge clock_i) begin
    if (reset_i) begin
      small_ext_ram_sel_o <= 1'b0;
      large_ext_ram_sel_o <= 1'b0;
      large_ext_ram_addr_o <= 14'h0000;
      first_can_sel_o <= 1'b0;
      second_can_sel_o <= 1'b0;
      rtc_sel_o <= 1'b0;
      pwm_sel_o <= 1'b0;
      asc_sel_o <= 1'b0;
      ssc_sel_o <= 1'b0;
      i2c_sel_o <= 1'b0;
      misc_sel_o <= 1'b0;
      sfr_sel_o <= 1'b0;
      flash_sector_sel_o <= 1'b0;
      flash_sector_o <= 3'h0;
      test_sector_sel_o <= 1'b0;
      flash_ctrl_sel_o <= 1'b0;
      flash_reserved_sel_o <= 1'b0;
      external_sel_o <= 1'b0;
      wait_states_o <= 2'h0;
      demux_addr_o <= 1'b0;
      word_only_o <= 1'b0;
      wide_fetch_o <= 1'b0;
      seg_lines_o <= `OMD_FULL_SEG_LINES;
    end else begin
      // Windows are disjoint, so at most one select is high
      small_ext_ram_sel_o <= req_i && hit_sram;
      large_ext_ram_sel_o <= req_i && hit_lram;
      large_ext_ram_addr_o <= addr_i[13:0];
      first_can_sel_o <= req_i && hit_first_can;
      second_can_sel_o <= req_i && hit_second_can;
      rtc_sel_o <= req_i && hit_rtc;
      pwm_sel_o <= req_i && hit_pwm;
      asc_sel_o <= req_i && hit_asc;
      ssc_sel_o <= req_i && hit_ssc;
      i2c_sel_o <= req_i && hit_i2c;
      misc_sel_o <= req_i && hit_misc;
      sfr_sel_o <= req_i && hit_sfr;
      flash_sector_sel_o <= req_i && f_sect_hit;
      flash_sector_o <= f_sect;
      test_sector_sel_o <= req_i && f_test_hit;
      flash_ctrl_sel_o <= req_i && hit_fctl;
      flash_reserved_sel_o <= req_i && hit_frsv;
      external_sel_o <= req_i && !hit_any;
      wait_states_o <= (req_i && hit_per) ? `OMD_WAIT_STATES : 2'h0;
      demux_addr_o <= req_i && (hit_per | hit_sram | hit_lram);
      // Word-only windows; byte access there is the requester's fault
      word_only_o <= req_i && (hit_per | hit_sfr);
      wide_fetch_o <= req_i && fetch_i && (f_sect_hit | f_test_hit);
      seg_lines_o <= (first_can_enable | second_can_enable) ?
        `OMD_CAN_SEG_LINES : `OMD_FULL_SEG_LINES;
    end
  end

endmodule // omd_decoder

// ==================================================
// Inclusive address window compare, shared by every on-chip target except the flash and test sectors
module omd_window_hit #(
  parameter [23:0] LO = 24'h000000,
  parameter [23:0] HI = 24'h000000
) (
  input wire [23:0] addr_i,
  output wire hit_o
);

  assign hit_o = (addr_i >= LO) && (addr_i <= HI);

endmodule // omd_window_hit

// file: verilog/omd_regs.vh
// Purpose: constants for the on-chip memory map decoder
// Assumes: 24-bit byte addresses, 100 MHz clock
// Notes: windows are given as base and last address, peripherals as a page, large RAM as base and span
`ifndef OMD_REGS_VH
`define OMD_REGS_VH
`define OMD_GLOBAL_EN_BIT 2
`define OMD_EN_FIRST_CAN 0
`define OMD_EN_SECOND_CAN 1
`define OMD_EN_SRAM 2
`define OMD_EN_LRAM 3
`define OMD_EN_RTC 4
`define OMD_EN_PWM 6
`define OMD_EN_ASC 7
`define OMD_EN_SSC 8
`define OMD_EN_I2C 9
`define OMD_EN_MISC 10
`define OMD_SRAM_LO 24'h00e000
`define OMD_SRAM_HI 24'h00e7ff
`define OMD_LRAM_BASE 24'h090000
`define OMD_LRAM_SIZE_BITS 14
`define OMD_LRAM_SPAN 24'h00ffff
`define OMD_PAGE_FIRST_CAN 16'h00ef
`define OMD_PAGE_SECOND_CAN 16'h00ee
`define OMD_PAGE_RTC 16'h00ed
`define OMD_PAGE_PWM 16'h00ec
`define OMD_PAGE_I2C 16'h00ea
`define OMD_PAGE_MISC 16'h00eb
`define OMD_PAGE_ASC 16'h00e9
`define OMD_PAGE_SSC 16'h00e8
`define OMD_SFR_LO 24'h00f000
`define OMD_SFR_HI 24'h00f3ff
`define OMD_FLASH_HI 24'h04ffff
`define OMD_FRSV_LO 24'h050000
`define OMD_FRSV_HI 24'h07ffff
`define OMD_FCTL_LO 24'h080000
`define OMD_FCTL_HI 24'h08ffff
`define OMD_LOW_SECT_HI 24'h007fff
`define OMD_SEG1_LO 24'h010000
`define OMD_SEG1_SECT_HI 24'h017fff
`define OMD_SECT4_LO 24'h018000
`define OMD_TEST_HI 24'h001fff
`define OMD_ACCESS_PS 62500
`define OMD_CLK_NS 10
`define OMD_WAIT_STATES 2'h2
`define OMD_CAN_SEG_LINES 4'h4
`define OMD_FULL_SEG_LINES 4'h8
`endif
